// ===== inc/dswdt_pkg.sv
// constants, field layouts and carrier types of the default-start watchdog
// assumes a classic wishbone slave port and source clocks sampled as pins
package dswdt_pkg;

  // register byte addresses
  localparam logic [31:0] DSWDT_ADDR_MODE    = 32'hFFFF_F6D0;
  localparam logic [31:0] DSWDT_ADDR_SERVICE = 32'hFFFF_F6D4;
  localparam logic [31:0] DSWDT_ADDR_STATUS  = 32'hFFFF_F6D8;

  // register values
  localparam logic [7:0]  DSWDT_MODE_RESET   = 8'h67;
  localparam logic [7:0]  DSWDT_SERVICE_KEY  = 8'hAC;
  localparam logic [7:0]  DSWDT_SERVICE_READ = 8'h9A;
  localparam logic [3:0]  DSWDT_SEL_BYTE     = 4'h1;

  // counter and prescaler geometry
  localparam int          DSWDT_CNT_W        = 16;
  localparam int          DSWDT_PRE_W        = 9;
  localparam logic [4:0]  DSWDT_TAP_BASE     = 5'h09;
  localparam logic [8:0]  DSWDT_PRE_OSC      = 9'h007;
  localparam logic [8:0]  DSWDT_PRE_MAIN     = 9'h1FF;
  localparam logic [8:0]  DSWDT_PRE_SUB      = 9'h000;

  // status register field positions
  localparam int          DSWDT_ST_WRITTEN   = 16;
  localparam int          DSWDT_ST_OSC_STOP  = 17;
  localparam int          DSWDT_ST_MAIN_HALT = 18;

  // mode register layout
  typedef struct packed {
    logic       fixed_zero;
    logic       overflow_action_hi;
    logic       overflow_action_lo;
    logic       source_sel_top;
    logic       source_sel_main;
    logic [2:0] interval_sel;
  } dswdt_mode_t;

  // classic wishbone request bundle
  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } dswdt_wb_req_t;

endpackage

// ===== rtl/dswdt_sync.sv
// two-flop synchroniser with rising-edge pulse for one pin input
// assumes the pin is asynchronous to the block clock
`timescale 1ns/100ps
module dswdt_sync (
  input  wire logic clk_i,   // block clock
  input  wire logic rst_i,   // async reset, active high
  input  wire logic pin_i,   // raw asynchronous pin
  output logic      level_o, // synchronised level
  output logic      rise_o   // one-cycle pulse on a rising edge
);

  logic meta_reg;  // first stage, read only by the second
  logic sync_reg;  // second stage
  logic prev_reg;  // previous synchronised level
  logic meta_next;
  logic sync_next;
  logic prev_next;

  // next values of the chain
  always_comb begin
    meta_next = pin_i;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // register stage; metastability settles between meta and sync
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~prev_reg;

endmodule

// ===== rtl/dswdt_top.sv
// default-start watchdog: mode and service registers on wishbone,
// prescaled source selection, 16-bit counter, overflow actions
// assumes source clocks arrive as slow pins far below the 250 MHz clock
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
module dswdt_top
  import dswdt_pkg::*;
(
  input  wire logic        REF_CLK_I,         // 250 MHz block clock
  input  wire logic        RST_I,             // async reset, active high
  input  wire logic [31:0] ADR_I,             // wishbone byte address
  input  wire logic [31:0] DAT_I,             // wishbone write data
  input  wire logic [3:0]  SEL_I,             // wishbone byte selects
  input  wire logic        WE_I,              // wishbone write enable
  input  wire logic        CYC_I,             // wishbone cycle
  input  wire logic        STB_I,             // wishbone strobe
  output logic      [31:0] DAT_O,             // wishbone read data
  output logic             ACK_O,             // wishbone acknowledge
  input  wire logic        INT_OSC_CLK_I,     // internal oscillator clock
  input  wire logic        MAIN_CLK_I,        // main clock, divided source
  input  wire logic        SUB_CLK_I,         // subclock
  input  wire logic        INT_OSC_STOP_I,    // internal oscillator halted
  input  wire logic        MAIN_CLK_HALT_I,   // main clock stopped (idle)
  output logic             WATCHDOG_RESET_O,  // internal reset request
  output logic             WATCHDOG_NMI_O     // non-maskable irq request
);

  // bus request bundle
  dswdt_wb_req_t wb_req;
  assign wb_req = '{adr: ADR_I, dat: DAT_I, sel: SEL_I, we: WE_I,
                    cyc: CYC_I, stb: STB_I};

  // synchronised source pins
  logic osc_rise;       // internal oscillator edge
  logic main_rise;      // main clock edge
  logic sub_rise;       // subclock edge
  logic osc_stop_lvl;   // oscillator halted
  logic main_halt_lvl;  // main clock halted

  dswdt_sync u_sync_osc (
    .clk_i   (REF_CLK_I),
    .rst_i   (RST_I),
    .pin_i   (INT_OSC_CLK_I),
    .level_o (),
    .rise_o  (osc_rise)
  );

  dswdt_sync u_sync_main (
    .clk_i   (REF_CLK_I),
    .rst_i   (RST_I),
    .pin_i   (MAIN_CLK_I),
    .level_o (),
    .rise_o  (main_rise)
  );

  dswdt_sync u_sync_sub (
    .clk_i   (REF_CLK_I),
    .rst_i   (RST_I),
    .pin_i   (SUB_CLK_I),
    .level_o (),
    .rise_o  (sub_rise)
  );

  dswdt_sync u_sync_stop (
    .clk_i   (REF_CLK_I),
    .rst_i   (RST_I),
    .pin_i   (INT_OSC_STOP_I),
    .level_o (osc_stop_lvl),
    .rise_o  ()
  );

  dswdt_sync u_sync_halt (
    .clk_i   (REF_CLK_I),
    .rst_i   (RST_I),
    .pin_i   (MAIN_CLK_HALT_I),
    .level_o (main_halt_lvl),
    .rise_o  ()
  );

  // prescaler terminal mask for the selected source
  function automatic logic [DSWDT_PRE_W-1:0] pre_mask(input dswdt_mode_t m);
    if (m.source_sel_top) begin
      pre_mask = DSWDT_PRE_SUB;
    end else if (m.source_sel_main) begin
      pre_mask = DSWDT_PRE_MAIN;
    end else begin
      pre_mask = DSWDT_PRE_OSC;
    end
  endfunction

  // counter tap mask: 2^(9+sel) prescaled ticks per interval
  function automatic logic [DSWDT_CNT_W-1:0] tap_mask(input dswdt_mode_t m);
    logic [4:0] bits;
    bits     = DSWDT_TAP_BASE + {2'b00, m.interval_sel};
    tap_mask = ~({DSWDT_CNT_W{1'b1}} << bits);
  endfunction

  // state registers
  dswdt_mode_t            mode_reg;      // watchdog_mode_config
  dswdt_mode_t            mode_next;
  logic                   written_reg;   // first write already taken
  logic                   written_next;
  logic [DSWDT_PRE_W-1:0] pre_reg;       // source prescaler
  logic [DSWDT_PRE_W-1:0] pre_next;
  logic [DSWDT_CNT_W-1:0] cnt_reg;       // 16-bit interval counter
  logic [DSWDT_CNT_W-1:0] cnt_next;
  logic                   rst_out_reg;   // watchdog_reset_out
  logic                   rst_out_next;
  logic                   nmi_reg;       // watchdog_nmi_request
  logic                   nmi_next;
  logic                   ack_reg;       // bus acknowledge
  logic                   ack_next;
  logic [31:0]            rdata_reg;     // bus read data
  logic [31:0]            rdata_next;

  // decode helpers
  logic bus_req;      // new request, not yet acknowledged
  logic wr_req;       // write request
  logic byte_acc;     // exactly the low byte lane
  logic hit_mode;     // mode register addressed
  logic hit_service;  // service register addressed
  logic hit_status;   // status register addressed
  logic stopped;      // mode field selects stop
  logic src_tick;     // one tick of the selected, gated source
  logic pre_done;     // prescaler wraps this tick
  logic cnt_done;     // interval expired this tick
  logic forced;       // software forced overflow
  logic service;      // valid service write
  logic first_cfg;    // first mode write taken now
  logic overflow;     // overflow event, natural or forced

  // bus decode
  always_comb begin
    bus_req     = wb_req.cyc & wb_req.stb & ~ack_reg;
    wr_req      = bus_req & wb_req.we;
    byte_acc    = (wb_req.sel == DSWDT_SEL_BYTE);
    hit_mode    = (wb_req.adr == DSWDT_ADDR_MODE);
    hit_service = (wb_req.adr == DSWDT_ADDR_SERVICE);
    hit_status  = (wb_req.adr == DSWDT_ADDR_STATUS);
  end

  // event decode
  always_comb begin
    stopped = ~mode_reg.overflow_action_hi
            & ~mode_reg.overflow_action_lo;
    // a halted oscillator or idle main clock delivers no ticks
    if (mode_reg.source_sel_top) begin
      src_tick = sub_rise;
    end else if (mode_reg.source_sel_main) begin
      src_tick = main_rise & ~main_halt_lvl;
    end else begin
      src_tick = osc_rise & ~osc_stop_lvl;
    end
    pre_done  = src_tick
              & ((pre_reg & pre_mask(mode_reg)) == pre_mask(mode_reg));
    cnt_done  = pre_done
              & ((cnt_reg & tap_mask(mode_reg)) == tap_mask(mode_reg));
    first_cfg = wr_req & hit_mode & byte_acc & ~written_reg;
    service   = wr_req & hit_service & byte_acc
              & (wb_req.dat[7:0] == DSWDT_SERVICE_KEY);
    // any later mode write, wrong key, or service write with byte selects other than the low lane alone forces it
    forced    = (wr_req & hit_mode & written_reg)
              | (wr_req & hit_service & byte_acc
                 & (wb_req.dat[7:0] != DSWDT_SERVICE_KEY))
              | (wr_req & hit_service & ~byte_acc);
    // a service write landing in the expiry cycle still counts as in time
    overflow  = ~stopped & ((cnt_done & ~service) | forced);
  end

  // next state of configuration, counter and outputs
  always_comb begin
    mode_next    = mode_reg;
    written_next = written_reg;
    pre_next     = pre_reg;
    cnt_next     = cnt_reg;
    rst_out_next = 1'b0;
    nmi_next     = 1'b0;
    if (first_cfg) begin
      // bit 7 is hard-wired low whatever software writes
      mode_next            = dswdt_mode_t'(wb_req.dat[7:0]);
      mode_next.fixed_zero = 1'b0;
      written_next         = 1'b1;
    end
    if (first_cfg || service || overflow || stopped) begin
      // restart the interval; a stopped watchdog sits at zero
      pre_next = '0;
      cnt_next = '0;
    end else if (src_tick) begin
      // counting starts from reset with no software help
      pre_next = pre_done ? '0 : pre_reg + 1'b1;
      if (pre_done) begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
    if (overflow) begin
      // upper action bit wins over the lower one
      if (mode_reg.overflow_action_hi) begin
        rst_out_next = 1'b1;
      end else begin
        nmi_next = 1'b1;
      end
    end
  end

  // bus answer: one-cycle ack, unmapped reads return zero
  always_comb begin
    ack_next   = bus_req;
    rdata_next = '0;
    if (bus_req && !wb_req.we) begin
      if (hit_mode) begin
        rdata_next[7:0] = mode_reg;
      end else if (hit_service) begin
        rdata_next[7:0] = DSWDT_SERVICE_READ;
      end else if (hit_status) begin
        rdata_next[DSWDT_CNT_W-1:0]   = cnt_reg;
        rdata_next[DSWDT_ST_WRITTEN]  = written_reg;
        rdata_next[DSWDT_ST_OSC_STOP] = osc_stop_lvl;
        rdata_next[DSWDT_ST_MAIN_HALT] = main_halt_lvl;
      end else begin
        rdata_next = '0;
      end
    end
  end

  // registers; the mode default starts the watchdog in reset mode
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_reg    <= dswdt_mode_t'(DSWDT_MODE_RESET);
      written_reg <= 1'b0;
      pre_reg     <= '0;
      cnt_reg     <= '0;
      rst_out_reg <= 1'b0;
      nmi_reg     <= 1'b0;
      ack_reg     <= 1'b0;
      rdata_reg   <= '0;
    end else begin
      mode_reg    <= mode_next;
      written_reg <= written_next;
      pre_reg     <= pre_next;
      cnt_reg     <= cnt_next;
      rst_out_reg <= rst_out_next;
      nmi_reg     <= nmi_next;
      ack_reg     <= ack_next;
      rdata_reg   <= rdata_next;
    end
  end

  // outputs straight from flops
  assign DAT_O            = rdata_reg;
  assign ACK_O            = ack_reg;
  assign WATCHDOG_RESET_O = rst_out_reg;
  assign WATCHDOG_NMI_O   = nmi_reg;

endmodule

// ===== test/dswdt_monitor.sv
// checker for the watchdog top: bus handshake, reads, overflow pulses
// assumes it is bound onto dswdt_top and sees only its ports
`timescale 1ns/100ps
module dswdt_monitor
  import dswdt_pkg::*;
(
  input  wire logic        REF_CLK_I,        // block clock
  input  wire logic        RST_I,            // async reset, high
  input  wire logic [31:0] ADR_I,            // bus address
  input  wire logic [31:0] DAT_I,            // bus write data
  input  wire logic [3:0]  SEL_I,            // byte selects
  input  wire logic        WE_I,             // write enable
  input  wire logic        CYC_I,            // bus cycle
  input  wire logic        STB_I,            // bus strobe
  input  wire logic [31:0] DAT_O,            // read data
  input  wire logic        ACK_O,            // acknowledge
  input  wire logic        WATCHDOG_RESET_O, // reset request
  input  wire logic        WATCHDOG_NMI_O    // nmi request
);
  logic req; // request taken at this edge
  assign req = CYC_I && STB_I && !ACK_O;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  a_ack_after_req: assert property (req |=> ACK_O)
    else $error("no ack one cycle after a request");
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");
  a_idle_data_zero: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_service_read: assert property (
    ACK_O && $past(!WE_I && ADR_I == DSWDT_ADDR_SERVICE)
    |-> DAT_O == 32'h0000_009A)
    else $error("service register read wrong");
  a_mode_top_zero: assert property (
    ACK_O && $past(!WE_I && ADR_I == DSWDT_ADDR_MODE)
    |-> DAT_O[31:7] == 25'h0)
    else $error("mode register bit 7 not zero");
  a_key_no_action: assert property (
    req && WE_I && SEL_I == DSWDT_SEL_BYTE
    && ADR_I == DSWDT_ADDR_SERVICE && DAT_I[7:0] == DSWDT_SERVICE_KEY
    |=> !WATCHDOG_NMI_O && !WATCHDOG_RESET_O)
    else $error("service key caused an overflow action");
  a_nmi_pulse: assert property (WATCHDOG_NMI_O |=> !WATCHDOG_NMI_O)
    else $error("nmi request longer than one cycle");
  a_rst_pulse: assert property (
    $rose(WATCHDOG_RESET_O) |=> $fell(WATCHDOG_RESET_O))
    else $error("reset request longer than one cycle");
  a_one_action: assert property (
    !(WATCHDOG_NMI_O && WATCHDOG_RESET_O))
    else $error("nmi and reset requested together");
  a_quiet_release: assert property (
    $fell(RST_I) |-> !ACK_O && !WATCHDOG_NMI_O && !WATCHDOG_RESET_O)
    else $error("outputs active at reset release");
endmodule

bind dswdt_top dswdt_monitor i_dswdt_monitor (.REF_CLK_I, .RST_I, .ADR_I,
  .DAT_I, .SEL_I, .WE_I, .CYC_I, .STB_I, .DAT_O, .ACK_O, .WATCHDOG_RESET_O,
  .WATCHDOG_NMI_O);

// ===== test/dswdt_top_tb.sv
// self-checking bench for the watchdog top over classic wishbone
// assumes the source pins may toggle with three cycles per level
`timescale 1ns/100ps
module dswdt_top_tb
  import dswdt_pkg::*;
;
  logic        clk = 1'b0;       // 250 MHz clock
  logic        rst = 1'b1;       // reset, held at start
  logic [31:0] adr = '0;         // bus address
  logic [31:0] wdat = '0;        // bus write data
  logic [3:0]  sel = '0;         // byte selects
  logic        we = 1'b0;        // write enable
  logic        cyc = 1'b0;       // bus cycle
  logic        stb = 1'b0;       // bus strobe
  logic [31:0] rdat;             // read data
  logic        ack;              // acknowledge
  logic [2:0]  src = '0;         // osc, main, sub pins
  logic        osc_stop = 1'b0;  // oscillator halted
  logic        main_halt = 1'b0; // main clock halted
  logic        wdt_rst;          // reset request
  logic        wdt_nmi;          // nmi request
  int          mismatches = 0;   // failed comparisons
  int          checks = 0;       // comparisons made
  int          nmi_n = 0;        // nmi pulses seen
  int          rst_n = 0;        // reset pulses seen
  int          n0;               // nmi count before a step
  logic [31:0] seed = 32'h4313_eb87; // xorshift state
  logic [31:0] rd;               // last read data
  logic [31:0] r;                // random word
  logic [7:0]  v;                // mode byte in use

  dswdt_top i_dswdt_top (.REF_CLK_I(clk), .RST_I(rst), .ADR_I(adr),
    .DAT_I(wdat), .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb),
    .DAT_O(rdat), .ACK_O(ack), .INT_OSC_CLK_I(src[0]), .MAIN_CLK_I(src[1]),
    .SUB_CLK_I(src[2]), .INT_OSC_STOP_I(osc_stop),
    .MAIN_CLK_HALT_I(main_halt), .WATCHDOG_RESET_O(wdt_rst),
    .WATCHDOG_NMI_O(wdt_nmi));

  always #2 clk = ~clk;

  // pulse counters, so a one-cycle pulse is never missed
  always @(posedge clk) begin
    if (wdt_nmi === 1'b1) nmi_n <= nmi_n + 1;
    if (wdt_rst === 1'b1) rst_n <= rst_n + 1;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected pulses, reset count times two plus nmi count
  function automatic logic [31:0] act(input logic [1:0] m);
    return m[1] ? 32'h0000_0002 : {31'h0, m[0]};
  endfunction

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", what, e, g);
    end
  endtask

  // one classic cycle; held until ack is sampled, then released
  // only the bench's 60000-cycle hang timeout ends a wait for ack
  // accesses model a cpu on the fast clock only
  task automatic wb(input logic w, input logic [31:0] a,
                    input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // write and count the overflow pulses it produces
  task automatic poke(input logic [31:0] a, input logic [7:0] d,
                      input logic [3:0] s);
    int p0;
    p0 = rst_n * 2 + nmi_n;
    wb(1'b1, a, d, s);
    repeat (4) @(posedge clk);
    chk("overflow action", act(v[6:5]), 32'(rst_n * 2 + nmi_n - p0));
  endtask

  // rising edges on one source pin, slow enough for the synchroniser
  task automatic edges(input int k, input int n);
    repeat (n) begin
      src[k] <= 1'b1;
      repeat (3) @(posedge clk);
      src[k] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // a hang counts as a failure; the scenarios need about 14,500 cycles
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  initial begin
    do_reset();
    wb(1'b0, DSWDT_ADDR_MODE, 8'h00, DSWDT_SEL_BYTE);
    chk("mode reset", 32'h0000_0067, rd);
    wb(1'b0, DSWDT_ADDR_SERVICE, 8'h00, DSWDT_SEL_BYTE);
    chk("service read", 32'h0000_009A, rd);
    wb(1'b0, 32'hFFFF_F6DC, 8'h00, DSWDT_SEL_BYTE);
    chk("unmapped read", 32'h0000_0000, rd);
    edges(0, 64);
    wb(1'b0, DSWDT_ADDR_STATUS, 8'h00, DSWDT_SEL_BYTE);
    chk("osc count", 32'h0000_0008, rd);
    osc_stop <= 1'b1;
    main_halt <= 1'b1;
    repeat (8) @(posedge clk);
    edges(0, 64);
    wb(1'b0, DSWDT_ADDR_STATUS, 8'h00, DSWDT_SEL_BYTE);
    chk("osc halted", 32'h0006_0008, rd);
    osc_stop <= 1'b0;
    main_halt <= 1'b0;
    // every action mode with random select bits, forced overflows
    for (int i = 0; i < 8; i++) begin
      do_reset();
      r = rnd();
      v = r[7:0];
      v[6:5] = i[1:0];
      wb(1'b1, DSWDT_ADDR_MODE, v, DSWDT_SEL_BYTE);
      wb(1'b0, DSWDT_ADDR_MODE, 8'h00, DSWDT_SEL_BYTE);
      chk("mode readback", {25'h0, v[6:0]}, rd);
      if (r[15:8] == DSWDT_SERVICE_KEY) r[15:8] = 8'h00;
      poke(DSWDT_ADDR_SERVICE, r[15:8], DSWDT_SEL_BYTE);
      poke(DSWDT_ADDR_MODE, r[23:16], DSWDT_SEL_BYTE);
    end
    // main clock source: 512 edges make one counter step, idle halts it
    do_reset();
    v = 8'h48;
    wb(1'b1, DSWDT_ADDR_MODE, v, DSWDT_SEL_BYTE);
    edges(1, 512);
    wb(1'b0, DSWDT_ADDR_STATUS, 8'h00, DSWDT_SEL_BYTE);
    chk("main count", 32'h0001_0001, rd);
    main_halt <= 1'b1;
    repeat (8) @(posedge clk);
    edges(1, 512);
    wb(1'b0, DSWDT_ADDR_STATUS, 8'h00, DSWDT_SEL_BYTE);
    chk("main halted", 32'h0005_0001, rd);
    main_halt <= 1'b0;
    // unused watchdog: oscillator off and 00h before any overflow
    do_reset();
    osc_stop <= 1'b1;
    v = 8'h00;
    wb(1'b1, DSWDT_ADDR_MODE, v, DSWDT_SEL_BYTE);
    osc_stop <= 1'b0;
    edges(0, 64);
    wb(1'b0, DSWDT_ADDR_STATUS, 8'h00, DSWDT_SEL_BYTE);
    chk("stopped count", 32'h0001_0000, rd);
    poke(DSWDT_ADDR_SERVICE, 8'h00, DSWDT_SEL_BYTE);
    // nmi mode on the subclock, shortest interval; main select ignored
    do_reset();
    v = 8'hB8;
    wb(1'b1, DSWDT_ADDR_MODE, v, 4'h2);
    wb(1'b0, DSWDT_ADDR_MODE, 8'h00, DSWDT_SEL_BYTE);
    chk("mode refused", 32'h0000_0067, rd);
    wb(1'b1, DSWDT_ADDR_MODE, v, DSWDT_SEL_BYTE);
    wb(1'b0, DSWDT_ADDR_MODE, 8'h00, DSWDT_SEL_BYTE);
    chk("mode bit7", 32'h0000_0038, rd);
    edges(2, 300);
    wb(1'b0, DSWDT_ADDR_STATUS, 8'h00, DSWDT_SEL_BYTE);
    chk("sub count", 32'h0001_012C, rd);
    wb(1'b1, DSWDT_ADDR_SERVICE, DSWDT_SERVICE_KEY, DSWDT_SEL_BYTE);
    n0 = nmi_n;
    edges(2, 511);
    chk("no early nmi", n0, nmi_n);
    edges(2, 1);
    chk("interval nmi", n0 + 1, nmi_n);
    edges(2, 300);
    poke(DSWDT_ADDR_MODE, 8'h00, DSWDT_SEL_BYTE);
    wb(1'b0, DSWDT_ADDR_STATUS, 8'h00, DSWDT_SEL_BYTE);
    chk("count cleared", 32'h0001_0000, rd);
    poke(DSWDT_ADDR_SERVICE, DSWDT_SERVICE_KEY, 4'h2);
    end_sim();
  end
endmodule
